// File: rtl/rsqr_report.sv
// rx signal quality report: frame append, strength averaging, apb registers
`timescale 1ns/1ps
`include "rsqr_map.svh"
module rsqr_report
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [13:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// receiver datapath
	input  wire logic        symbolTick,
	input  wire logic [7:0]  rxPowerDbm,
	input  wire logic        preambleActive,
	input  wire logic [7:0]  chipCorr,
	input  wire logic        frameStart,
	input  wire logic        rxByteValid,
	input  wire logic [7:0]  rxByte,
	input  wire logic        frameEnd,
	input  wire logic        frameGood,
	// receive buffer write port
	output logic [7:0]       fifoWrData,
	output logic             fifoWrEn,
	output logic             fifoCommit,
	output logic             fifoDrop,
	// interrupt
	output logic             irq
);

	////////////////////////////////////////////////////////////////////////
	function automatic logic isIdx(input logic [13:0] addr, input logic [11:0] idx);
		isIdx = (addr[13:2] == idx);
	endfunction : isIdx

	// window of 1, 2, 4 or 8 symbols
	function automatic logic [2:0] avgLast(input logic [1:0] sel);
		avgLast = 3'((4'h1 << sel) - 4'h1);
	endfunction : avgLast

	////////////////////////////////////////////////////////////////////////
	rsqr_pkg::rsqr_main_s state_reg;
	rsqr_pkg::rsqr_main_s state_next;
	logic [7:0]           romCode;
	logic                 romValid;
	logic                 mapped;
	logic                 wrAcc;
	logic                 rdSetup;
	logic [1:0]           avgSel;
	logic                 reqWrite;
	logic                 completion;

	assign mapped = isIdx(paddr, `RSQR_IDX_BEACON_CTL) | isIdx(paddr, `RSQR_IDX_STRENGTH_CTL)
		| isIdx(paddr, `RSQR_IDX_STRENGTH_RES) | isIdx(paddr, `RSQR_IDX_IRQ_STATUS)
		| isIdx(paddr, `RSQR_IDX_IRQ_MASK);
	assign wrAcc   = psel & penable & pwrite & mapped;
	assign rdSetup = psel & ~penable & ~pwrite;
	assign avgSel  = state_reg.beaconCtl[`RSQR_AVG_MSB:`RSQR_AVG_LSB];
	assign reqWrite = wrAcc & isIdx(paddr, `RSQR_IDX_STRENGTH_CTL) & pwdata[`RSQR_BIT_REQUEST];
	assign completion = romValid & state_reg.romTag & state_reg.reqPending;

	rsqr_strength_rom u_rom
	(
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.lookupEn  (state_reg.romGo),
		.powerDbm  (state_reg.romDbm),
		.codeOut   (romCode),
		.codeValid (romValid)
	);

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		logic [2:0]         irqEvent;
		logic [2:0]         irqClr;
		logic [9:0]         lqiTotal;
		logic signed [10:0] avgSum;
		irqEvent = 3'h0;
		irqClr   = 3'h0;
		lqiTotal = state_reg.lqiSum + {2'h0, chipCorr};
		avgSum   = $signed(state_reg.avgAcc) + $signed({{3{rxPowerDbm[7]}}, rxPowerDbm});

		state_next = state_reg;
		state_next.fifoWr     = 1'b0;
		state_next.fifoCommit = 1'b0;
		state_next.fifoDrop   = 1'b0;
		state_next.romGo      = 1'b0;
		state_next.prevPre    = preambleActive;

		// read data latched in the setup cycle so prdata is a flop
		if (rdSetup)
		begin
			state_next.prdata = 32'h0000_0000;
			if (isIdx(paddr, `RSQR_IDX_BEACON_CTL))
				state_next.prdata[7:0] = state_reg.beaconCtl;
			else if (isIdx(paddr, `RSQR_IDX_STRENGTH_CTL))
				state_next.prdata[7:0] = {state_reg.reqPending, state_reg.appendEn, 5'h00, state_reg.doneFlag};
			else if (isIdx(paddr, `RSQR_IDX_STRENGTH_RES))
				state_next.prdata[7:0] = state_reg.strengthRes;
			else if (isIdx(paddr, `RSQR_IDX_IRQ_STATUS))
				state_next.prdata[2:0] = state_reg.irqStat;
			else if (isIdx(paddr, `RSQR_IDX_IRQ_MASK))
				state_next.prdata[2:0] = state_reg.irqMask;
		end

		// register writes
		if (wrAcc && isIdx(paddr, `RSQR_IDX_BEACON_CTL))
			state_next.beaconCtl = {pwdata[7:4], 4'h0};
		if (wrAcc && isIdx(paddr, `RSQR_IDX_STRENGTH_CTL))
			state_next.appendEn = pwdata[`RSQR_BIT_APPEND];
		if (wrAcc && isIdx(paddr, `RSQR_IDX_IRQ_MASK))
			state_next.irqMask = pwdata[2:0];
		if (wrAcc && isIdx(paddr, `RSQR_IDX_IRQ_STATUS))
			irqClr = pwdata[2:0];

		// link quality: three preamble symbols, restarted at each preamble
		if (preambleActive && !state_reg.prevPre)
		begin
			state_next.lqiCnt = 2'h0;
			state_next.lqiSum = 10'h000;
		end
		else if (preambleActive && symbolTick && state_reg.lqiCnt != `RSQR_LQI_SYMBOLS)
		begin
			state_next.lqiCnt = state_reg.lqiCnt + 2'h1;
			state_next.lqiSum = lqiTotal;
			if (state_reg.lqiCnt == `RSQR_LQI_SYMBOLS - 2'h1)
				state_next.lqiVal = 8'(lqiTotal / 10'd3);
		end

		// strength averaging; a new request restarts the window
		if (reqWrite)
		begin
			state_next.avgCnt = 3'h0;
			state_next.avgAcc = 11'h000;
		end
		else if (symbolTick)
		begin
			if (state_reg.avgCnt == avgLast(avgSel))
			begin
				state_next.romDbm = 8'(avgSum >>> avgSel);
				state_next.romGo  = 1'b1;
				state_next.romTag = state_reg.reqPending;
				state_next.avgCnt = 3'h0;
				state_next.avgAcc = 11'h000;
			end
			else
			begin
				state_next.avgCnt = state_reg.avgCnt + 3'h1;
				state_next.avgAcc = 11'(avgSum);
			end
		end
		if (romValid)
			state_next.lastCode = romCode;

		// done flag: the hardware set wins over the clear by a new request
		if (reqWrite)
			state_next.doneFlag = 1'b0;
		if (completion)
		begin
			state_next.strengthRes = romCode;
			state_next.doneFlag    = 1'b1;
			state_next.reqPending  = 1'b0;
			irqEvent[`RSQR_IRQ_DONE] = 1'b1;
		end
		if (reqWrite)
			state_next.reqPending = 1'b1;

		// frame pass-through and trailer append
		case (state_reg.st)
			rsqr_pkg::ST_IDLE:
			begin
				if (frameStart)
					state_next.st = rsqr_pkg::ST_PASS;
			end
			rsqr_pkg::ST_PASS:
			begin
				if (rxByteValid)
				begin
					state_next.fifoData = rxByte;
					state_next.fifoWr   = 1'b1;
				end
				if (frameEnd && frameGood)
					state_next.st = rsqr_pkg::ST_LQI;
				else if (frameEnd)
				begin
					state_next.fifoDrop = 1'b1;
					irqEvent[`RSQR_IRQ_DROPPED] = 1'b1;
					state_next.st = rsqr_pkg::ST_IDLE;
				end
			end
			rsqr_pkg::ST_LQI:
			begin
				state_next.fifoData = state_reg.lqiVal;
				state_next.fifoWr   = 1'b1;
				if (state_reg.appendEn)
					state_next.st = rsqr_pkg::ST_SIGNAL_STRENGTH_RESULT;
				else
				begin
					state_next.fifoCommit = 1'b1;
					irqEvent[`RSQR_IRQ_STORED] = 1'b1;
					state_next.st = rsqr_pkg::ST_IDLE;
				end
			end
			rsqr_pkg::ST_SIGNAL_STRENGTH_RESULT:
			begin
				state_next.fifoData   = state_reg.lastCode;
				state_next.fifoWr     = 1'b1;
				state_next.fifoCommit = 1'b1;
				irqEvent[`RSQR_IRQ_STORED] = 1'b1;
				state_next.st = rsqr_pkg::ST_IDLE;
			end
			default:
			begin
				state_next.st = rsqr_pkg::ST_IDLE;
			end
		endcase

		// sticky status: an event in the clearing cycle survives
		state_next.irqStat = (state_reg.irqStat & ~irqClr) | irqEvent;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			state_reg           <= '0;
			state_reg.st        <= rsqr_pkg::ST_IDLE;
			state_reg.beaconCtl <= `RSQR_RST_BEACON_CTL;
			state_reg.irqStat   <= `RSQR_RST_IRQ;
			state_reg.irqMask   <= `RSQR_RST_IRQ;
			state_reg.lastCode  <= `RSQR_RST_BYTE;
		end
		else
			state_reg <= state_next;
	end

	////////////////////////////////////////////////////////////////////////
	assign prdata     = state_reg.prdata;
	assign pready     = 1'b1;
	assign pslverr    = psel & penable & ~mapped;
	assign fifoWrData = state_reg.fifoData;
	assign fifoWrEn   = state_reg.fifoWr;
	assign fifoCommit = state_reg.fifoCommit;
	assign fifoDrop   = state_reg.fifoDrop;
	assign irq        = |(state_reg.irqStat & state_reg.irqMask);

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence s_good_end;
		state_reg.st == rsqr_pkg::ST_PASS && frameEnd && frameGood;
	endsequence

	sequence s_lqi_write;
		fifoWrEn && fifoWrData == $past(state_reg.lqiVal);
	endsequence

	property p_lqi_after_frame;
		s_good_end |=> ##1 s_lqi_write;
	endproperty
	a_lqi_after_frame: assert property (p_lqi_after_frame) else $error("link quality byte missing");

	property p_strength_appended;
		(s_good_end ##0 state_reg.appendEn) |=> ##2 (fifoWrEn && fifoCommit && fifoWrData == $past(state_reg.lastCode));
	endproperty
	a_strength_appended: assert property (p_strength_appended) else $error("strength byte missing");

	property p_no_strength_when_off;
		(state_reg.st == rsqr_pkg::ST_LQI && !state_reg.appendEn) |=> fifoCommit ##1 !fifoWrEn;
	endproperty
	a_no_strength_when_off: assert property (p_no_strength_when_off) else $error("extra byte appended");

	property p_lqi_three_symbols;
		(preambleActive && state_reg.prevPre && symbolTick && state_reg.lqiCnt == 2'h2)
			|=> state_reg.lqiCnt == 2'h3 && state_reg.lqiVal == 8'(($past(state_reg.lqiSum) + {2'h0, $past(chipCorr)}) / 10'd3);
	endproperty
	a_lqi_three_symbols: assert property (p_lqi_three_symbols) else $error("link quality not from three symbols");

	property p_avg_window;
		(symbolTick && !reqWrite && state_reg.avgCnt == avgLast(avgSel)) |=> state_reg.romGo ##1 romValid;
	endproperty
	a_avg_window: assert property (p_avg_window) else $error("averaging window length wrong");

	property p_done_result;
		completion |=> state_reg.doneFlag && (!state_reg.reqPending || $past(reqWrite))
			&& state_reg.strengthRes == $past(romCode);
	endproperty
	a_done_result: assert property (p_done_result) else $error("done flag or result not set");

	property p_request_clears_done;
		(reqWrite && !completion) |=> !state_reg.doneFlag && state_reg.reqPending;
	endproperty
	a_request_clears_done: assert property (p_request_clears_done) else $error("request did not clear done");

	property p_bad_frame_dropped;
		(state_reg.st == rsqr_pkg::ST_PASS && frameEnd && !frameGood) |=> fifoDrop ##1 !fifoWrEn;
	endproperty
	a_bad_frame_dropped: assert property (p_bad_frame_dropped) else $error("bad frame not dropped");

endmodule : rsqr_report

// File: rtl/rsqr_map.svh
// register indices, field positions, reset values and counts of the signal quality block
`ifndef RSQR_MAP_SVH
`define RSQR_MAP_SVH

// register indices; byte address is four times the index
`define RSQR_IDX_BEACON_CTL   12'h025
`define RSQR_IDX_STRENGTH_CTL 12'h03e
`define RSQR_IDX_STRENGTH_RES 12'h210
`define RSQR_IDX_IRQ_STATUS   12'h300
`define RSQR_IDX_IRQ_MASK     12'h301

// field positions
`define RSQR_BIT_REQUEST      7
`define RSQR_BIT_APPEND       6
`define RSQR_BIT_DONE         0
`define RSQR_AVG_MSB          5
`define RSQR_AVG_LSB          4
`define RSQR_IRQ_DONE         0
`define RSQR_IRQ_STORED       1
`define RSQR_IRQ_DROPPED      2

// reset values
`define RSQR_RST_BEACON_CTL   8'h00
`define RSQR_RST_BYTE         8'h00
`define RSQR_RST_IRQ          3'h0

// counts and strength limits
`define RSQR_LQI_SYMBOLS      2'h3
`define RSQR_FLOOR_DBM        (-8'sd90)
`define RSQR_CEIL_DBM         (-8'sd35)
`define RSQR_TABLE_LEN        54

`endif

// File: rtl/rsqr_pkg.sv
// types of the signal quality block
package rsqr_pkg;

	typedef enum logic [1:0] {ST_IDLE, ST_PASS, ST_LQI, ST_SIGNAL_STRENGTH_RESULT} rsqr_state_e;

	typedef struct packed {
		rsqr_state_e st;
		logic [7:0]  beaconCtl;
		logic        reqPending;
		logic        appendEn;
		logic        doneFlag;
		logic [7:0]  strengthRes;
		logic [2:0]  irqStat;
		logic [2:0]  irqMask;
		logic [31:0] prdata;
		logic [7:0]  fifoData;
		logic        fifoWr;
		logic        fifoCommit;
		logic        fifoDrop;
		logic        prevPre;
		logic [1:0]  lqiCnt;
		logic [9:0]  lqiSum;
		logic [7:0]  lqiVal;
		logic [2:0]  avgCnt;
		logic [10:0] avgAcc;
		logic [7:0]  lastCode;
		logic [7:0]  romDbm;
		logic        romGo;
		logic        romTag;
	} rsqr_main_s;

	typedef struct packed {
		logic [7:0] code;
		logic       valid;
	} rsqr_rom_s;

endpackage : rsqr_pkg

// File: rtl/rsqr_strength_rom.sv
// power to strength code lookup with registered output
`timescale 1ns/1ps
`include "rsqr_map.svh"
module rsqr_strength_rom
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// lookup request
	input  wire logic        lookupEn,
	input  wire logic [7:0]  powerDbm,
	// lookup answer
	output logic [7:0]       codeOut,
	output logic             codeValid
);

	localparam logic [7:0] TABLE [0:`RSQR_TABLE_LEN-1] = '{
		8'h01, 8'h02, 8'h05, 8'h09, 8'h0d, 8'h12, 8'h17, 8'h1b, 8'h20, 8'h25,
		8'h2b, 8'h30, 8'h35, 8'h3a, 8'h3f, 8'h44, 8'h49, 8'h4e, 8'h53, 8'h59,
		8'h5f, 8'h64, 8'h6b, 8'h6f, 8'h75, 8'h79, 8'h7d, 8'h81, 8'h85, 8'h8a,
		8'h8f, 8'h94, 8'h99, 8'h9f, 8'ha5, 8'haa, 8'hb0, 8'hb7, 8'hbc, 8'hc1,
		8'hc6, 8'hcb, 8'hcf, 8'hd4, 8'hd8, 8'hdd, 8'he1, 8'he4, 8'he9, 8'hef,
		8'hf5, 8'hfa, 8'hfd, 8'hfe};

	rsqr_pkg::rsqr_rom_s rom_reg;
	rsqr_pkg::rsqr_rom_s rom_next;
	logic [7:0]          tableIdx;

	assign tableIdx = 8'($signed(powerDbm) - `RSQR_FLOOR_DBM - 8'sd1);

	always_comb
	begin
		rom_next = rom_reg;
		rom_next.valid = lookupEn;
		if (lookupEn)
		begin
			// saturate at both ends
			if ($signed(powerDbm) <= `RSQR_FLOOR_DBM)
				rom_next.code = 8'h00;
			else if ($signed(powerDbm) >= `RSQR_CEIL_DBM)
				rom_next.code = 8'hff;
			else
				rom_next.code = TABLE[tableIdx[5:0]];
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			rom_reg <= '0;
		else
			rom_reg <= rom_next;
	end

	assign codeOut   = rom_reg.code;
	assign codeValid = rom_reg.valid;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	property p_floor;
		(lookupEn && $signed(powerDbm) <= `RSQR_FLOOR_DBM) |=> (codeOut == 8'h00) && codeValid;
	endproperty
	a_floor: assert property (p_floor) else $error("weak power not coded zero");

	property p_ceiling;
		(lookupEn && $signed(powerDbm) >= `RSQR_CEIL_DBM) |=> (codeOut == 8'hff) && codeValid;
	endproperty
	a_ceiling: assert property (p_ceiling) else $error("strong power not coded full scale");

	property p_point;
		(lookupEn && powerDbm == 8'hc4) |=> codeOut == 8'h8a;
	endproperty
	a_point: assert property (p_point) else $error("minus sixty dbm code wrong");

	// single-symbol windows on ticks two cycles apart, as the bench drives them, give lookups two cycles apart
	sequence s_rising_pair;
		lookupEn ##2 (lookupEn && $signed(powerDbm) > $signed($past(powerDbm, 2)));
	endsequence

	property p_monotone;
		s_rising_pair |=> codeOut >= $past(codeOut, 2);
	endproperty
	a_monotone: assert property (p_monotone) else $error("strength code not monotone");

endmodule : rsqr_strength_rom

// File: tb/rsqr_host_model.sv
// host side model of the receive buffer behind the write port
`timescale 1ns/1ps
module rsqr_host_model
(
	// clock
	input  wire logic       ref_clk,
	// buffer write port
	input  wire logic [7:0] fifoWrData,
	input  wire logic       fifoWrEn,
	input  wire logic       fifoCommit,
	input  wire logic       fifoDrop
);
	logic [7:0] curQ[$];
	logic [7:0] lastQ[$];
	int         nCommit = 0;
	int         nDrop = 0;

	////////////////////////////////////////////////////////////////
	// raw correlation to a byte-wide quality figure
	function automatic int quality(input logic [7:0] chip_correlation_value);
		int q;
		q = (int'(chip_correlation_value) - 50) * 4;
		if (q < 0)
			q = 0;
		if (q > 255)
			q = 255;
		return q;
	endfunction : quality

	////////////////////////////////////////////////////////////////
	// a byte on the commit cycle still belongs to the frame
	always @(posedge ref_clk)
	begin
		if (fifoWrEn)
			curQ.push_back(fifoWrData);
		if (fifoCommit)
		begin
			lastQ = curQ;
			curQ.delete();
			nCommit++;
		end
		if (fifoDrop)
		begin
			curQ.delete();
			nDrop++;
		end
	end
endmodule : rsqr_host_model

// File: tb/rsqr_report_tb.sv
// self-checking bench of the signal quality block
`timescale 1ns/1ps
`include "rsqr_map.svh"
module rsqr_report_tb;
	logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
	logic [13:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        symbolTick, preambleActive, frameStart, rxByteValid, frameEnd, frameGood;
	logic [7:0]  rxPowerDbm, chipCorr, rxByte, fifoWrData;
	logic        fifoWrEn, fifoCommit, fifoDrop, se;
	int          errCount = 0;
	int          nTests = 0;
	int          c0;

	rsqr_report dut (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .symbolTick, .rxPowerDbm, .preambleActive, .chipCorr, .frameStart, .rxByteValid,
		.rxByte, .frameEnd, .frameGood, .fifoWrData, .fifoWrEn, .fifoCommit, .fifoDrop, .irq);
	rsqr_host_model host (.ref_clk, .fifoWrData, .fifoWrEn, .fifoCommit, .fifoDrop);

	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	////////////////////////////////////////////////////////////////
	task automatic giveVerdict;
		if (errCount == 0 && nTests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : giveVerdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		nTests++;
		if (got !== exp)
		begin
			errCount++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// request held until pready is seen high at an edge
	task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= {idx, 2'h0}; pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		for (n = 0; n < 16; n++)
		begin
			@(posedge ref_clk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		se = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		if (n == 16)
		begin
			errCount++;
			giveVerdict();
		end
	endtask : apb

	task automatic tick(input int p, input logic [7:0] c);
		@(posedge ref_clk);
		symbolTick <= 1'b1; rxPowerDbm <= 8'(p); chipCorr <= c;
		@(posedge ref_clk);
		symbolTick <= 1'b0;
	endtask : tick

	// first tick at p0, the rest at p1, then poll done
	task automatic meas(input logic [1:0] sel, input int p0, input int p1, input logic [7:0] code);
		int i;
		apb(1'b1, `RSQR_IDX_BEACON_CTL, {26'h0, sel, 4'h0});
		apb(1'b1, `RSQR_IDX_STRENGTH_CTL, 32'h80);
		for (i = 0; i < (1 << sel); i++)
			tick(i == 0 ? p0 : p1, 8'h00);
		for (i = 0; i < 20; i++)
		begin
			apb(1'b0, `RSQR_IDX_STRENGTH_CTL, 32'h0);
			if (rd[0] === 1'b1)
				break;
		end
		chk(rd, 32'h01);
		apb(1'b0, `RSQR_IDX_STRENGTH_RES, 32'h0);
		chk(rd, {24'h0, code});
	endtask : meas

	task automatic preamble;
		@(posedge ref_clk);
		preambleActive <= 1'b1;
		// rising power also exercises the monotone check on the lookup
		tick(-62, 8'd60);
		tick(-61, 8'd61);
		tick(-60, 8'd62);
		preambleActive <= 1'b0;
	endtask : preamble

	// last byte arrives with the frame end
	task automatic frame(input logic good, input int n);
		int i;
		@(posedge ref_clk);
		frameStart <= 1'b1;
		@(posedge ref_clk);
		frameStart <= 1'b0;
		for (i = 0; i < n; i++)
		begin
			rxByteValid <= 1'b1; rxByte <= 8'h10 + 8'(i); frameEnd <= (i == n - 1); frameGood <= good;
			@(posedge ref_clk);
		end
		rxByteValid <= 1'b0; frameEnd <= 1'b0;
		repeat (5) @(posedge ref_clk);
	endtask : frame

	task automatic s_regs;
		apb(1'b0, `RSQR_IDX_STRENGTH_CTL, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, `RSQR_IDX_BEACON_CTL, 32'hff);
		apb(1'b0, `RSQR_IDX_BEACON_CTL, 32'h0);
		chk(rd, 32'hf0);
		apb(1'b1, `RSQR_IDX_STRENGTH_CTL, 32'h41);
		apb(1'b0, `RSQR_IDX_STRENGTH_CTL, 32'h0);
		chk(rd, 32'h40);
		apb(1'b0, 12'h100, 32'h0);
		chk({rd[30:0], se}, 32'h1);
	endtask : s_regs

	// window length tells apart every averaging setting
	task automatic s_meas;
		meas(2'h1, -80, -40, 8'h8a);
		meas(2'h2, -80, -40, 8'hc1);
		meas(2'h3, -80, -40, 8'hd8);
		meas(2'h0, -100, 0, 8'h00);
		meas(2'h0, -90, 0, 8'h00);
		meas(2'h0, -89, 0, 8'h01);
		meas(2'h0, -35, 0, 8'hff);
		meas(2'h0, -20, 0, 8'hff);
		meas(2'h0, -60, 0, 8'h8a);
	endtask : s_meas

	task automatic s_irq;
		chk(irq, 1'b0);
		apb(1'b1, `RSQR_IDX_IRQ_MASK, 32'h7);
		// mask lands at the access edge; look once it has settled
		@(posedge ref_clk);
		chk(irq, 1'b1);
		apb(1'b1, `RSQR_IDX_IRQ_STATUS, 32'h1);
		apb(1'b0, `RSQR_IDX_IRQ_STATUS, 32'h0);
		chk({rd[31:1], irq}, 32'h0);
	endtask : s_irq

	task automatic s_frames;
		apb(1'b1, `RSQR_IDX_STRENGTH_CTL, 32'h40);
		preamble();
		c0 = host.nCommit;
		frame(1'b1, 5);
		chk(host.nCommit - c0, 1);
		chk(host.lastQ.size(), 7);
		chk(host.lastQ[4], 8'h14);
		chk(host.lastQ[5], 8'h3d);
		chk(host.lastQ[6], 8'h8a);
		chk(host.quality(host.lastQ[5]), 44);
		apb(1'b0, `RSQR_IDX_IRQ_STATUS, 32'h0);
		chk({rd[30:0], irq}, 32'h5);
		apb(1'b1, `RSQR_IDX_IRQ_STATUS, 32'h2);
		apb(1'b1, `RSQR_IDX_STRENGTH_CTL, 32'h00);
		frame(1'b1, 4);
		chk(host.lastQ.size(), 5);
		chk(host.lastQ[4], 8'h3d);
		c0 = host.nDrop;
		frame(1'b0, 3);
		chk(host.nDrop - c0, 1);
		chk(host.nCommit, 2);
		apb(1'b0, `RSQR_IDX_IRQ_STATUS, 32'h0);
		chk(rd, 32'h6);
	endtask : s_frames

	////////////////////////////////////////////////////////////////
	initial
	begin
		rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 14'h0; pwdata = 32'h0;
		symbolTick = 1'b0; rxPowerDbm = 8'h00; preambleActive = 1'b0; chipCorr = 8'h00;
		frameStart = 1'b0; rxByteValid = 1'b0; rxByte = 8'h00; frameEnd = 1'b0; frameGood = 1'b0;
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		s_regs();
		s_meas();
		s_irq();
		s_frames();
		giveVerdict();
	end
endmodule : rsqr_report_tb
